// File: pcs_map.svh
// Purpose: named offsets, fields, reset values and timing figures of the precharge sequencer
// Assumes: byte addresses on the plain register port, 32-bit words
// Notes:   definitions only
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

`define PCS_CLK_HZ          64'd250000000
`define PCS_SEQ_LIMIT_S     64'd30
`define PCS_MAIN_DELAY_MS   64'd1000

`define PCS_PCT_RATED       32'd100
`define PCS_PCT_OVER        32'd115
`define PCS_PCT_RESIST      32'd90

`define PCS_ADDR_CFG        4'h0
`define PCS_ADDR_CTRL       4'h4
`define PCS_ADDR_STATUS     4'h8

`define PCS_CFG_TYPE_LSB    0
`define PCS_CFG_TYPE_MSB    1
`define PCS_CFG_RESET       2'h0
`define PCS_CTRL_FRST_BIT   0

`define PCS_ST_STATE_MSB    9
`define PCS_ST_CAUSE_LSB    10
`define PCS_ST_CAUSE_MSB    11
`define PCS_ST_TYPE_LSB     12
`define PCS_ST_TYPE_MSB     13

`endif

// File: pcs_pkg.sv
// Purpose: types shared by the precharge sequencer
// Assumes: nothing beyond the map header
// Notes:   one-hot state codes written out
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_MBB = 2'h0,
    PCS_BBM = 2'h1,
    PCS_RES = 2'h2
  } pcs_type_e;

  typedef enum logic [1:0] {
    PCS_CAUSE_NONE    = 2'h0,
    PCS_CAUSE_TIMEOUT = 2'h1,
    PCS_CAUSE_OVERV   = 2'h2,
    PCS_CAUSE_DROPPED = 2'h3
  } pcs_cause_e;

  typedef enum logic [9:0] {
    PCS_IDLE     = 10'h001,
    PCS_CHARGE   = 10'h002,
    PCS_DAMP     = 10'h004,
    PCS_OPEN_CHG = 10'h008,
    PCS_MAIN_DLY = 10'h010,
    PCS_MAIN     = 10'h020,
    PCS_UNDAMP   = 10'h040,
    PCS_DONE     = 10'h080,
    PCS_READY    = 10'h100,
    PCS_FAULT    = 10'h200
  } pcs_state_e;

  typedef struct packed {
    logic main_contactor_close;
    logic damping_contactor_close;
    logic charge_contactor_close;
  } pcs_cmd_s;

  typedef struct packed {
    logic main_contactor_ack;
    logic damping_contactor_ack;
    logic charge_contactor_ack;
  } pcs_ack_s;

endpackage

// File: pcs_sequencer.sv
// Purpose: precharge contactor sequencer for three sequence types
// Assumes: inputs synchronous to mclk_i; phase voltages in raw sensor units, RATED_V = 100%
// Notes:   plain register port, read data valid one cycle after the read strobe
//
// Overview of operation
// - start dropped before completion aborts the sequence with a fault
// - start received closes the charge contactor in every type
// - charge contactor never acknowledging ends in a timeout fault
// - make-before-break: damping closes at 100% voltage and no cell bus low
// - the largest of three phase voltages is compared, not the average
// - voltage above 115% during the sequence aborts with overvoltage fault
// - make-before-break: damping acknowledge opens the charge contactor
// - make-before-break: charge acknowledge false closes the main contactor
// - make-before-break: main acknowledge opens damping; none means abort
// - make-before-break: damping acknowledge false sets complete
// - controller withdraws start after complete, else timeout fault
// - break-before-make: rated voltage opens charge contactor, no damping stage
// - break-before-make: charge acknowledge false commands main contactor
// - break-before-make: delay between main close flag and main output
// - break-before-make: main acknowledge sets complete, none means timeout fault
// - permissive and ready only after complete and start withdrawn
// - resistive type follows break-before-make but stops at 90%
// - controlled source: charge command and status also enable the source
// - whole sequence must finish within 30 seconds of start
// - any fault clears permissive, complete and all contactor commands
// - no new attempt until the latched fault is reset
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pcs_map.svh"

module pcs_sequencer #(
  parameter int unsigned VW         = 16,
  parameter logic [15:0] RATED_V    = 16'h4000,
  parameter logic [35:0] SEQ_LIMIT  = 36'(`PCS_SEQ_LIMIT_S * `PCS_CLK_HZ),
  parameter logic [31:0] MAIN_DELAY = 32'(`PCS_MAIN_DELAY_MS * `PCS_CLK_HZ / 64'd1000)
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  start_command_i,
  input  wire pcs_pkg::pcs_ack_s     ack_i,
  input  wire logic                  cell_bus_low_i,
  input  wire logic [2:0][VW-1:0]    phase_v_i,
  input  wire logic [3:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic [31:0]                rdata_o,
  output pcs_pkg::pcs_cmd_s          cmd_o,
  output logic                       charge_fault_o,
  output logic                       charge_complete_o,
  output logic                       drive_permissive_o,
  output logic                       drive_ready_o,
  output logic                       main_close_flag_o,
  output logic                       charge_source_en_o
);

  localparam logic [VW-1:0] THR_RATED  = VW'(32'(RATED_V) * `PCS_PCT_RATED / 32'd100);
  localparam logic [VW-1:0] THR_RESIST = VW'(32'(RATED_V) * `PCS_PCT_RESIST / 32'd100);
  localparam logic [VW-1:0] THR_OVER   = VW'(32'(RATED_V) * `PCS_PCT_OVER / 32'd100);

  pcs_pkg::pcs_state_e st_q, st_d;
  pcs_pkg::pcs_type_e  type_q, cfg_type_q;
  pcs_pkg::pcs_cause_e cause_q, cause_d;
  pcs_pkg::pcs_cmd_s   cmd_d;
  logic [35:0]         seq_cnt_q;
  logic [31:0]         dly_cnt_q;
  logic [VW-1:0]       vmax;
  logic [VW-1:0]       stop_thr;
  logic                active;
  logic                overv;
  logic                timed_out;
  logic                fault_reset;
  logic                is_mbb;

  // peak, not mean: phases are unbalanced while resonating
  always_comb begin
    vmax = phase_v_i[0];
    if (phase_v_i[1] > vmax) begin
      vmax = phase_v_i[1];
    end
    if (phase_v_i[2] > vmax) begin
      vmax = phase_v_i[2];
    end
  end

  assign is_mbb      = (type_q == pcs_pkg::PCS_MBB);
  assign stop_thr    = (type_q == pcs_pkg::PCS_RES) ? THR_RESIST : THR_RATED;
  assign overv       = (vmax > THR_OVER);
  assign timed_out   = (seq_cnt_q >= SEQ_LIMIT);
  assign fault_reset = wr_i && (addr_i == `PCS_ADDR_CTRL) && wdata_i[`PCS_CTRL_FRST_BIT];
  assign active      = st_q inside {pcs_pkg::PCS_CHARGE, pcs_pkg::PCS_DAMP, pcs_pkg::PCS_OPEN_CHG,
                                    pcs_pkg::PCS_MAIN_DLY, pcs_pkg::PCS_MAIN, pcs_pkg::PCS_UNDAMP,
                                    pcs_pkg::PCS_DONE};

  // next state; aborts take priority over sequence progress
  always_comb begin
    st_d    = st_q;
    cause_d = cause_q;
    if (active && overv) begin
      st_d    = pcs_pkg::PCS_FAULT;
      cause_d = pcs_pkg::PCS_CAUSE_OVERV;
    end else if (active && !start_command_i && st_q != pcs_pkg::PCS_DONE) begin
      st_d    = pcs_pkg::PCS_FAULT;
      cause_d = pcs_pkg::PCS_CAUSE_DROPPED;
    end else if (active && timed_out) begin
      // covers missing acks and a start that is never withdrawn
      st_d    = pcs_pkg::PCS_FAULT;
      cause_d = pcs_pkg::PCS_CAUSE_TIMEOUT;
    end else begin
      unique case (st_q)
        pcs_pkg::PCS_IDLE: begin
          if (start_command_i) begin
            st_d    = pcs_pkg::PCS_CHARGE;
            cause_d = pcs_pkg::PCS_CAUSE_NONE;
          end
        end
        pcs_pkg::PCS_CHARGE: begin
          if (vmax >= stop_thr) begin
            if (!is_mbb) begin
              st_d = pcs_pkg::PCS_OPEN_CHG;
            end else if (!cell_bus_low_i) begin
              st_d = pcs_pkg::PCS_DAMP;
            end
          end
        end
        pcs_pkg::PCS_DAMP: begin
          if (ack_i.damping_contactor_ack) begin
            st_d = pcs_pkg::PCS_OPEN_CHG;
          end
        end
        pcs_pkg::PCS_OPEN_CHG: begin
          if (!ack_i.charge_contactor_ack) begin
            st_d = is_mbb ? pcs_pkg::PCS_MAIN : pcs_pkg::PCS_MAIN_DLY;
          end
        end
        pcs_pkg::PCS_MAIN_DLY: begin
          if (dly_cnt_q >= MAIN_DELAY) begin
            st_d = pcs_pkg::PCS_MAIN;
          end
        end
        pcs_pkg::PCS_MAIN: begin
          if (ack_i.main_contactor_ack) begin
            st_d = is_mbb ? pcs_pkg::PCS_UNDAMP : pcs_pkg::PCS_DONE;
          end
        end
        pcs_pkg::PCS_UNDAMP: begin
          if (!ack_i.damping_contactor_ack) begin
            st_d = pcs_pkg::PCS_DONE;
          end
        end
        pcs_pkg::PCS_DONE: begin
          if (!start_command_i) begin
            st_d = pcs_pkg::PCS_READY;
          end
        end
        pcs_pkg::PCS_READY: begin
          // main stays closed for ride-through until software resets
          if (fault_reset) begin
            st_d = pcs_pkg::PCS_IDLE;
          end
        end
        pcs_pkg::PCS_FAULT: begin
          if (fault_reset) begin
            st_d = pcs_pkg::PCS_IDLE;
          end
        end
        default: begin
          st_d    = pcs_pkg::PCS_FAULT;
          cause_d = pcs_pkg::PCS_CAUSE_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q    <= pcs_pkg::PCS_IDLE;
      cause_q <= pcs_pkg::PCS_CAUSE_NONE;
    end else begin
      st_q    <= st_d;
      cause_q <= cause_d;
    end
  end

  // type latched at start only, so a config change mid-sequence has no effect
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      type_q <= pcs_pkg::PCS_MBB;
    end else if (st_q == pcs_pkg::PCS_IDLE) begin
      type_q <= cfg_type_q;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seq_cnt_q <= '0;
    end else if (!active) begin
      seq_cnt_q <= '0;
    end else if (!timed_out) begin
      seq_cnt_q <= seq_cnt_q + 36'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_cnt_q <= '0;
    end else if (st_q != pcs_pkg::PCS_MAIN_DLY) begin
      dly_cnt_q <= '0;
    end else begin
      dly_cnt_q <= dly_cnt_q + 32'h1;
    end
  end

  // commands decoded from the next state so outputs come straight from flops
  always_comb begin
    cmd_d = '0;
    unique case (st_d)
      pcs_pkg::PCS_CHARGE: cmd_d.charge_contactor_close = 1'b1;
      pcs_pkg::PCS_DAMP: begin
        cmd_d.charge_contactor_close  = 1'b1;
        cmd_d.damping_contactor_close = 1'b1;
      end
      pcs_pkg::PCS_OPEN_CHG: cmd_d.damping_contactor_close = is_mbb;
      pcs_pkg::PCS_MAIN: begin
        cmd_d.main_contactor_close    = 1'b1;
        cmd_d.damping_contactor_close = is_mbb;
      end
      pcs_pkg::PCS_UNDAMP, pcs_pkg::PCS_DONE, pcs_pkg::PCS_READY: begin
        cmd_d.main_contactor_close = 1'b1;
      end
      default: cmd_d = '0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_o              <= '0;
      charge_fault_o     <= 1'b0;
      charge_complete_o  <= 1'b0;
      drive_permissive_o <= 1'b0;
      drive_ready_o      <= 1'b0;
      main_close_flag_o  <= 1'b0;
    end else begin
      cmd_o              <= cmd_d;
      charge_fault_o     <= (st_d == pcs_pkg::PCS_FAULT);
      charge_complete_o  <= st_d inside {pcs_pkg::PCS_DONE, pcs_pkg::PCS_READY};
      drive_permissive_o <= (st_d == pcs_pkg::PCS_READY);
      drive_ready_o      <= (st_d == pcs_pkg::PCS_READY);
      main_close_flag_o  <= st_d inside {pcs_pkg::PCS_MAIN_DLY, pcs_pkg::PCS_MAIN,
                                         pcs_pkg::PCS_UNDAMP, pcs_pkg::PCS_DONE, pcs_pkg::PCS_READY};
    end
  end

  // source runs only while its series contactor is both commanded and confirmed
  assign charge_source_en_o = (type_q == pcs_pkg::PCS_RES) && cmd_o.charge_contactor_close
                              && ack_i.charge_contactor_ack;

  // register port
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_type_q <= pcs_pkg::pcs_type_e'(`PCS_CFG_RESET);
    end else if (wr_i && addr_i == `PCS_ADDR_CFG) begin
      // the unused code folds onto the resistive type
      cfg_type_q <= (wdata_i[`PCS_CFG_TYPE_MSB:`PCS_CFG_TYPE_LSB] == 2'h0) ? pcs_pkg::PCS_MBB :
                    (wdata_i[`PCS_CFG_TYPE_MSB:`PCS_CFG_TYPE_LSB] == 2'h1) ? pcs_pkg::PCS_BBM :
                    pcs_pkg::PCS_RES;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        unique case (addr_i)
          `PCS_ADDR_CFG: rdata_o[`PCS_CFG_TYPE_MSB:`PCS_CFG_TYPE_LSB] <= cfg_type_q;
          `PCS_ADDR_STATUS: begin
            rdata_o[`PCS_ST_STATE_MSB:0]                   <= st_q;
            rdata_o[`PCS_ST_CAUSE_MSB:`PCS_ST_CAUSE_LSB]   <= cause_q;
            rdata_o[`PCS_ST_TYPE_MSB:`PCS_ST_TYPE_LSB]     <= type_q;
          end
          default: rdata_o <= '0;
        endcase
      end
    end
  end

  // checks
  property p_start_closes_charge;
    @(posedge mclk_i) disable iff (!rstn_i)
    (st_q == pcs_pkg::PCS_IDLE && start_command_i) |=> cmd_o.charge_contactor_close;
  endproperty
  a_start_closes_charge: assert property (p_start_closes_charge) else $error("charge not closed on start");

  property p_drop_faults;
    @(posedge mclk_i) disable iff (!rstn_i)
    (active && !start_command_i && st_q != pcs_pkg::PCS_DONE) |=> charge_fault_o && cmd_o == '0;
  endproperty
  a_drop_faults: assert property (p_drop_faults) else $error("dropped start did not fault");

  property p_overv_faults;
    @(posedge mclk_i) disable iff (!rstn_i)
    (active && overv) |=> charge_fault_o && cause_q == pcs_pkg::PCS_CAUSE_OVERV;
  endproperty
  a_overv_faults: assert property (p_overv_faults) else $error("overvoltage not flagged");

  property p_fault_clears;
    @(posedge mclk_i) disable iff (!rstn_i)
    charge_fault_o |-> cmd_o == '0 && !charge_complete_o && !drive_permissive_o;
  endproperty
  a_fault_clears: assert property (p_fault_clears) else $error("outputs active during fault");

  property p_fault_holds;
    @(posedge mclk_i) disable iff (!rstn_i)
    (charge_fault_o && !fault_reset) |=> charge_fault_o;
  endproperty
  a_fault_holds: assert property (p_fault_holds) else $error("fault left without reset");

  property p_damp_ack_opens_charge;
    @(posedge mclk_i) disable iff (!rstn_i)
    (st_q == pcs_pkg::PCS_DAMP && ack_i.damping_contactor_ack && start_command_i && !overv && !timed_out)
      |=> !cmd_o.charge_contactor_close && cmd_o.damping_contactor_close;
  endproperty
  a_damp_ack_opens_charge: assert property (p_damp_ack_opens_charge) else $error("charge kept closed");

  property p_permissive_after_withdraw;
    @(posedge mclk_i) disable iff (!rstn_i)
    $rose(drive_permissive_o) |-> $past(charge_complete_o) && $past(!start_command_i);
  endproperty
  a_permissive_after_withdraw: assert property (p_permissive_after_withdraw) else $error("early permissive");

  property p_bbm_main_delayed;
    @(posedge mclk_i) disable iff (!rstn_i)
    ($rose(cmd_o.main_contactor_close) && !is_mbb) |-> $past(st_q) == pcs_pkg::PCS_MAIN_DLY;
  endproperty
  a_bbm_main_delayed: assert property (p_bbm_main_delayed) else $error("main closed without delay");

  property p_timeout_faults;
    @(posedge mclk_i) disable iff (!rstn_i)
    (active && timed_out && !overv && start_command_i) |=> cause_q == pcs_pkg::PCS_CAUSE_TIMEOUT;
  endproperty
  a_timeout_faults: assert property (p_timeout_faults) else $error("timeout not flagged");

  c_ready_mbb: cover property (@(posedge mclk_i) disable iff (!rstn_i) drive_ready_o && is_mbb);
  c_ready_res: cover property (@(posedge mclk_i) disable iff (!rstn_i)
                               drive_ready_o && type_q == pcs_pkg::PCS_RES);
  c_overv:     cover property (@(posedge mclk_i) disable iff (!rstn_i)
                               charge_fault_o && cause_q == pcs_pkg::PCS_CAUSE_OVERV);

endmodule

// File: pcs_contactor_model.sv
// Purpose: far-side model of the precharge sequencer: three contactors and primary voltage sensing
// Assumes: acks follow commands after ack_dly_i cycles; voltage ramps while only the charge contactor is closed
// Notes:   no_close_i and no_open_i make the charge contactor fail on demand
`timescale 1ns/1ps
module pcs_contactor_model #(
  parameter logic [15:0] RATED_V = 16'h4000,
  parameter logic [15:0] STEP    = 16'h0040
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire pcs_pkg::pcs_cmd_s cmd_i,
  input  wire logic [3:0]        ack_dly_i,
  input  wire logic [1:0]        phase_sel_i,
  input  wire logic              no_close_i,
  input  wire logic              no_open_i,
  output pcs_pkg::pcs_ack_s      ack_o,
  output logic [15:0]            vmax_o,
  output logic [2:0][15:0]       phase_v_o
);
  logic [2:0]      cmd_w;
  logic [2:0][3:0] cnt_q;
  logic [15:0]     v_q;

  assign cmd_w  = cmd_i;
  assign vmax_o = v_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= '0;
      cnt_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ack_o[i] == cmd_w[i]) begin
          cnt_q[i] <= 4'h0;
        end else if (cnt_q[i] + 4'h1 < ack_dly_i) begin
          cnt_q[i] <= cnt_q[i] + 4'h1;
        end else if (!(i == 0 && (cmd_w[0] ? no_close_i : no_open_i))) begin
          ack_o[i] <= cmd_w[i];
          cnt_q[i] <= 4'h0;
        end
      end
    end
  end

  // no charge contactor, no rise: a stuck-open contactor leaves the primary dead
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      v_q <= 16'h0000;
    end else if (ack_o == '0) begin
      v_q <= 16'h0000;
    end else if (ack_o.main_contactor_ack) begin
      v_q <= RATED_V;
    end else if (ack_o.charge_contactor_ack && !ack_o.damping_contactor_ack) begin
      v_q <= v_q + STEP;
    end
  end

  // unbalanced phases: the average stays well below the peak
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      phase_v_o[i] = v_q >> 1;
    end
    phase_v_o[phase_sel_i] = v_q;
    phase_v_o[(phase_sel_i == 2'h2) ? 2'h0 : phase_sel_i + 2'h1] = v_q - (v_q >> 2);
  end
endmodule

// File: pcs_sequencer_test.sv
// Purpose: self-checking bench of the precharge sequencer
// Assumes: shortened sequence limit and main delay
// Notes:   output vector {main, damp, charge, flag, complete, fault, permissive, ready}
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_sequencer_test;
  localparam logic [35:0] SEQ_LIMIT  = 36'd2000;
  localparam logic [31:0] MAIN_DELAY = 32'd20;
  localparam logic [15:0] RATED_V    = 16'h4000;
  localparam logic [15:0] STEP       = 16'h0040;
  logic                mclk_i = 1'b0;
  logic                rstn_i, start, cbl, wr, rd, fault, complete, perm, ready, flag, src_en, no_close, no_open;
  logic [3:0]          addr, ack_dly;
  logic [31:0]         wdata, rdata;
  logic [1:0]          psel;
  logic [15:0]         vmax, prev_v, thr;
  logic [2:0][15:0]    phase_v;
  pcs_pkg::pcs_cmd_s   cmd;
  pcs_pkg::pcs_ack_s   ack;
  pcs_pkg::pcs_type_e  cur_type;
  logic [7:0]          ov, prev_ov;
  logic [7:0]          exp_ov[$];
  logic [31:0]         exp_rd[$];
  logic                prev_cbl, prev_start, rd_pend;
  int                  n_mismatch, num_checks, cyc, flag_cyc;

  always #2 mclk_i = ~mclk_i;
  assign ov  = {cmd, flag, complete, fault, perm, ready};
  assign thr = (cur_type == pcs_pkg::PCS_RES) ? 16'(32'(RATED_V) * 90 / 100) : RATED_V;

  pcs_sequencer #(.VW(16), .RATED_V(RATED_V), .SEQ_LIMIT(SEQ_LIMIT), .MAIN_DELAY(MAIN_DELAY)) u_dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .start_command_i(start), .ack_i(ack), .cell_bus_low_i(cbl),
    .phase_v_i(phase_v), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .cmd_o(cmd), .charge_fault_o(fault), .charge_complete_o(complete), .drive_permissive_o(perm),
    .drive_ready_o(ready), .main_close_flag_o(flag), .charge_source_en_o(src_en));

  pcs_contactor_model #(.RATED_V(RATED_V), .STEP(STEP)) u_model (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_i(cmd), .ack_dly_i(ack_dly), .phase_sel_i(psel),
    .no_close_i(no_close), .no_open_i(no_open), .ack_o(ack), .vmax_o(vmax), .phase_v_o(phase_v));

  task automatic note(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected %0t %s", $time, what);
    end
  endtask
  task automatic chk_ov(input logic [7:0] e, input logic [7:0] g);
    note(g === e, $sformatf("outputs %h, wanted %h", g, e));
  endtask
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
    note(g === e, $sformatf("read data %h, wanted %h", g, e));
  endtask
  task automatic chk_bit(input logic e, input logic g, input string what);
    note(g === e, what);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
  endtask
  task automatic wait_ov(input logic [7:0] v, input int lim);
    for (int k = 0; k < lim && ov !== v; k++) @(negedge mclk_i);
    chk_bit(1'b1, ov === v, "outputs never reached the awaited state");
  endtask
  task automatic idle();
    exp_ov.push_back(8'h00);
    wr_reg(`PCS_ADDR_CTRL, 32'h1);
    wait_ov(8'h00, 50);
    for (int k = 0; k < 50 && vmax != 16'h0; k++) @(posedge mclk_i);
  endtask

  // one clean sequence; hold keeps start up past completion
  task automatic run(input pcs_pkg::pcs_type_e t, input logic hold);
    cur_type = t;
    wr_reg(`PCS_ADDR_CFG, 32'(t));
    ack_dly <= 4'(1 + $urandom % 8);
    psel    <= 2'($urandom % 3);
    cbl     <= 1'b1;
    if (t == pcs_pkg::PCS_MBB) exp_ov = '{8'h20, 8'h60, 8'h40, 8'hd0, 8'h90, 8'h98};
    else exp_ov = '{8'h20, 8'h00, 8'h10, 8'h90, 8'h98};
    exp_ov.push_back(hold ? 8'h04 : 8'h9b);
    @(posedge mclk_i);
    start <= 1'b1;
    if (hold) wr_reg(`PCS_ADDR_CFG, 32'h1);
    if (t == pcs_pkg::PCS_MBB) begin
      for (int k = 0; k < 600 && vmax < RATED_V + 3 * STEP; k++) @(posedge mclk_i);
    end
    cbl <= 1'b0;
    wait_ov(8'h98, 1500);
    if (hold) begin
      wait_ov(8'h04, 2100);
      rd_reg(`PCS_ADDR_STATUS, 32'h600 | (32'(t) << 12));
    end
    @(posedge mclk_i);
    start <= 1'b0;
    if (!hold) begin
      wait_ov(8'h9b, 10);
      rd_reg(`PCS_ADDR_STATUS, 32'h100 | (32'(t) << 12));
    end
    idle();
  endtask

  // how: 0 start dropped, 1 charge contactor never closes, 2 charge contactor never opens
  task automatic fault_run(input pcs_pkg::pcs_type_e t, input int how);
    cur_type = t;
    wr_reg(`PCS_ADDR_CFG, 32'(t));
    no_close <= (how == 1);
    no_open  <= (how == 2);
    exp_ov = '{8'h20};
    if (how == 2) exp_ov.push_back(8'h00);
    exp_ov.push_back(8'h04);
    @(posedge mclk_i);
    start <= 1'b1;
    if (how == 0) begin
      repeat (30) @(posedge mclk_i);
      start <= 1'b0;
    end
    wait_ov(8'h04, 2100);
    rd_reg(`PCS_ADDR_STATUS, 32'h200 | ((how == 0) ? 32'hc00 : (how == 1) ? 32'h400 : 32'h800) | (32'(t) << 12));
    @(posedge mclk_i);
    start    <= 1'b1;
    no_close <= 1'b0;
    no_open  <= 1'b0;
    repeat (10) @(posedge mclk_i);
    start <= 1'b0;
    idle();
  endtask

  always @(negedge mclk_i) begin
    cyc++;
    if (rstn_i) begin
      if (ov !== prev_ov) chk_ov(exp_ov.size() ? exp_ov.pop_front() : 8'hff, ov);
      if (ov[6] && !prev_ov[6]) chk_bit(1'b1, !prev_cbl && prev_v >= RATED_V, "damping closed early");
      if (!ov[5] && prev_ov[5] && !ov[6] && !ov[2])
        chk_bit(1'b1, prev_v >= thr && prev_v < thr + 4 * STEP, "charge opened off threshold");
      if (ov[4] && !prev_ov[4]) flag_cyc = cyc;
      if (ov[7] && !prev_ov[7] && prev_ov[4])
        chk_bit(1'b1, cyc - flag_cyc >= MAIN_DELAY && cyc - flag_cyc <= MAIN_DELAY + 2, "main delay");
      if (ov[0] && !prev_ov[0]) chk_bit(1'b0, prev_start, "ready with start held");
      chk_bit(cur_type == pcs_pkg::PCS_RES && cmd.charge_contactor_close && ack.charge_contactor_ack,
              src_en, "source enable");
      if (rd_pend) chk_rd(exp_rd.size() ? exp_rd.pop_front() : 32'hffffffff, rdata);
    end
    rd_pend    = rd;
    prev_ov    = ov;
    prev_v     = vmax;
    prev_cbl   = cbl;
    prev_start = start;
  end

  initial begin
    repeat (40000) @(posedge mclk_i);
    n_mismatch++;
    $display("unexpected %0t watchdog ran out", $time);
    end_of_test();
  end

  initial begin
    void'($urandom(32'h05691811));
    rstn_i = 1'b0; start = 1'b0; cbl = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0;
    ack_dly = 4'h1; psel = 2'h0; no_close = 1'b0; no_open = 1'b0; cur_type = pcs_pkg::PCS_MBB;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd_reg(`PCS_ADDR_CFG, 32'h0);
    wr_reg(`PCS_ADDR_CFG, 32'h3);
    rd_reg(`PCS_ADDR_CFG, 32'h2);
    rd_reg(4'hc, 32'h0);
    rd_reg(`PCS_ADDR_CTRL, 32'h0);
    for (int t = 0; t < 3; t++) run(pcs_pkg::pcs_type_e'(t), 1'b0);
    run(pcs_pkg::PCS_MBB, 1'b1);
    fault_run(pcs_pkg::PCS_BBM, 0);
    fault_run(pcs_pkg::PCS_MBB, 1);
    fault_run(pcs_pkg::PCS_BBM, 2);
    end_of_test();
  end
endmodule
